/* overcurrent_guard.sv */
/*
  Fast overcurrent guard: blanks the pulse-width outputs for the rest of a
  switching cycle on a comparator trip and raises the flag after the chosen
  number of consecutive tripped cycles.
  Assumes cycle_start is a one-clock pulse at each switching cycle boundary.
*/
`timescale 1ns/1ns
`default_nettype none
`include "share_trim_consts.svh"

module overcurrent_guard #(
  parameter int PWM_COUNT = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 cycle_start,
  input  wire logic                 overcurrent_trip,
  input  wire logic [1:0]           timeout_code,
  input  wire logic [PWM_COUNT-1:0] pwm_in,
  output var  logic [PWM_COUNT-1:0] pwm_out,
  output var  logic                 oc_event
);

  initial
  begin
    if (PWM_COUNT < 1) $error("PWM_COUNT must be at least 1");
  end

  share_trim_pkg::guard_state_type state;
  logic       blank;
  logic       tripped_cycle;
  logic [3:0] run_len;
  logic [3:0] needed;

  // ****************************************
  // blanking
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      blank <= 1'b0;
    else if (overcurrent_trip)
      blank <= 1'b1;
    else if (cycle_start)
      blank <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pwm_out <= '0;
    else if (overcurrent_trip || (blank && !cycle_start))
      pwm_out <= '0;
    else
      pwm_out <= pwm_in;
  end

  // ****************************************
  // consecutive-cycle count
  // ****************************************
  assign needed = 4'h1 << timeout_code;

  always_ff @(posedge clk)
  begin
    if (rst)
      tripped_cycle <= 1'b0;
    else if (cycle_start)
      tripped_cycle <= overcurrent_trip;
    else if (overcurrent_trip)
      tripped_cycle <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state    <= share_trim_pkg::guard_idle;
      run_len  <= 4'h0;
      oc_event <= 1'b0;
    end
    else
    begin
      oc_event <= 1'b0;
      if (cycle_start)
      begin
        case (state)
          share_trim_pkg::guard_idle,
          share_trim_pkg::guard_counting:
          begin
            if (!tripped_cycle)
            begin
              state   <= share_trim_pkg::guard_idle;
              run_len <= 4'h0;
            end
            else if (run_len + 4'h1 >= needed)
            begin
              state    <= share_trim_pkg::guard_flagged;
              run_len  <= 4'h0;
              oc_event <= 1'b1;
            end
            else
            begin
              state   <= share_trim_pkg::guard_counting;
              run_len <= run_len + 4'h1;
            end
          end
          share_trim_pkg::guard_flagged:
          begin
            // a new count starts once a cycle passes clean
            if (!tripped_cycle)
              state <= share_trim_pkg::guard_idle;
          end
          default:
          begin
            state   <= share_trim_pkg::guard_idle;
            run_len <= 4'h0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_TRIP_BLANKS: assert property (@(posedge clk) disable iff (rst)
    overcurrent_trip |=> pwm_out == '0)
    else $error("pwm outputs not blanked after a trip");

  AST_BLANK_UNTIL_CYCLE: assert property (@(posedge clk) disable iff (rst)
    (blank && !cycle_start && !overcurrent_trip) |=> pwm_out == '0)
    else $error("pwm output resumed inside a tripped cycle");

  AST_RESUME_NEXT_CYCLE: assert property (@(posedge clk) disable iff (rst)
    (cycle_start && !overcurrent_trip) |=> pwm_out == $past(pwm_in))
    else $error("pwm outputs did not resume at the new cycle");

  AST_FLAG_AFTER_COUNT: assert property (@(posedge clk) disable iff (rst)
    oc_event |-> $past(run_len) + 4'h1 >= $past(needed)
              && $past(run_len) + 4'h1 <= $past(needed))
    else $error("overcurrent flag raised at the wrong cycle count");

endmodule

`default_nettype wire

/* share_bus_vsb_trim_config.sv */
/*
  Configuration bank for volt-second balance gain, share-bus output and loop
  tuning, temperature converter gain trim and the fast overcurrent timeout,
  with event status, mask and one interrupt line.
  Assumes a single 250 MHz clock, synchronous inputs, a one-clock
  cycle_start pulse per switching cycle, and a register master that never
  raises both strobes at once.
*/
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "share_trim_consts.svh"

module share_bus_vsb_trim_config #(
  parameter int PWM_COUNT   = 4,
  parameter int SENSE_WIDTH = 12,
  parameter int SLOW_SETTLE_CYCLES = `VSB_SLOW_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
  parameter int FAST_SETTLE_CYCLES = `VSB_FAST_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output var  logic [7:0]             rdata,
  input  wire logic                   cycle_start,
  input  wire logic                   overcurrent_trip,
  input  wire logic [PWM_COUNT-1:0]   pwm_in,
  output var  logic [PWM_COUNT-1:0]   pwm_out,
  input  wire logic [SENSE_WIDTH-1:0] primary_current_sense,
  input  wire logic [SENSE_WIDTH-1:0] secondary_current_sense,
  input  wire logic                   share_digital,
  input  wire logic [SENSE_WIDTH-1:0] share_bus_level,
  output var  logic                   share_bus_output_pin,
  output var  logic                   share_update,
  output var  logic [SENSE_WIDTH-1:0] share_current,
  output var  logic                   share_in_tolerance,
  output var  logic [3:0]             master_drop,
  output var  logic [6:0]             vsb_gain_mult,
  output var  logic                   vsb_settling,
  input  wire logic [SENSE_WIDTH-1:0] temp_raw,
  output var  logic [SENSE_WIDTH-1:0] temp_trimmed,
  output logic                        irq
);

  initial
  begin
    if (SENSE_WIDTH < 2 || SENSE_WIDTH > 24) $error("SENSE_WIDTH out of range");
    if (FAST_SETTLE_CYCLES < 1 || SLOW_SETTLE_CYCLES < FAST_SETTLE_CYCLES)
      $error("settle cycle counts inconsistent");
  end

  share_trim_pkg::reg_byte_type volt_second_gain;
  share_trim_pkg::reg_byte_type share_output_config;
  share_trim_pkg::reg_byte_type share_loop_tuning;
  share_trim_pkg::reg_byte_type thermal_adc_trim;
  share_trim_pkg::reg_byte_type fast_oc_config;
  share_trim_pkg::reg_byte_type active_vsg;
  share_trim_pkg::reg_byte_type active_soc;
  share_trim_pkg::reg_byte_type active_slt;
  share_trim_pkg::reg_byte_type active_tat;
  share_trim_pkg::reg_byte_type active_foc;
  logic [`EVT_COUNT-1:0]        event_status;
  logic [`EVT_COUNT-1:0]        event_mask;
  logic [`EVT_COUNT-1:0]        event_set;
  logic                         oc_event;
  logic                         in_tol_now;
  logic [SENSE_WIDTH-1:0]       share_diff;
  logic [31:0]                  settle_count;
  logic [31:0]                  settle_target;
  logic [SENSE_WIDTH+3:0]       trim_product;
  logic [SENSE_WIDTH:0]         trim_corr;
  logic [SENSE_WIDTH:0]         trim_sum;

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      volt_second_gain    <= `RESET_BYTE;
      share_output_config <= `RESET_BYTE;
      share_loop_tuning   <= `RESET_BYTE;
      thermal_adc_trim    <= `RESET_BYTE;
      fast_oc_config      <= `RESET_BYTE;
      event_mask          <= '0;
    end
    else if (wr)
    begin
      // reserved bits are stored too so they read back as written, except in the event mask, which keeps only its event bits
      case (addr)
        `OFS_VOLT_SECOND_GAIN:    volt_second_gain    <= wdata;
        `OFS_SHARE_OUTPUT_CONFIG: share_output_config <= wdata;
        `OFS_SHARE_LOOP_TUNING:   share_loop_tuning   <= wdata;
        `OFS_THERMAL_ADC_TRIM:    thermal_adc_trim    <= wdata;
        `OFS_FAST_OC_CONFIG:      fast_oc_config      <= wdata;
        `OFS_EVENT_MASK:          event_mask          <= wdata[`EVT_COUNT-1:0];
        default:                  ;
      endcase
    end
  end

  // ****************************************
  // switching-cycle shadows
  // ****************************************
  // a setting never changes mid-cycle, so a cycle never mixes two settings
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_vsg <= `RESET_BYTE;
      active_soc <= `RESET_BYTE;
      active_slt <= `RESET_BYTE;
      active_tat <= `RESET_BYTE;
      active_foc <= `RESET_BYTE;
    end
    else if (cycle_start)
    begin
      active_vsg <= volt_second_gain;
      active_soc <= share_output_config;
      active_slt <= share_loop_tuning;
      active_tat <= thermal_adc_trim;
      active_foc <= fast_oc_config;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= `READ_UNMAPPED;
    else if (rd)
    begin
      case (addr)
        `OFS_VOLT_SECOND_GAIN:    rdata <= volt_second_gain;
        `OFS_SHARE_OUTPUT_CONFIG: rdata <= share_output_config;
        `OFS_SHARE_LOOP_TUNING:   rdata <= share_loop_tuning;
        `OFS_THERMAL_ADC_TRIM:    rdata <= thermal_adc_trim;
        `OFS_FAST_OC_CONFIG:      rdata <= fast_oc_config;
        `OFS_EVENT_STATUS:        rdata <= {{(8-`EVT_COUNT){1'b0}}, event_status};
        `OFS_EVENT_MASK:          rdata <= {{(8-`EVT_COUNT){1'b0}}, event_mask};
        default:                  rdata <= `READ_UNMAPPED;
      endcase
    end
    else
      rdata <= `READ_UNMAPPED;
  end

  // ****************************************
  // fast overcurrent and share output
  // ****************************************
  overcurrent_guard #(
    .PWM_COUNT (PWM_COUNT)
  ) u_guard (
    .clk              (clk),
    .rst              (rst),
    .cycle_start      (cycle_start),
    .overcurrent_trip (overcurrent_trip),
    .timeout_code     (active_foc[`FOC_TIMEOUT_MSB:`FOC_TIMEOUT_LSB]),
    .pwm_in           (pwm_in),
    .pwm_out          (pwm_out),
    .oc_event         (oc_event)
  );

  share_select #(
    .SENSE_WIDTH (SENSE_WIDTH)
  ) u_share (
    .clk                     (clk),
    .rst                     (rst),
    .cycle_start             (cycle_start),
    .bitstream_sel           (active_soc[`SOC_STREAM_BIT]),
    .source_sel              (active_soc[`SOC_SRC_BIT]),
    .bandwidth               (active_soc[`SOC_BW_MSB:`SOC_BW_LSB]),
    .primary_current_sense   (primary_current_sense),
    .secondary_current_sense (secondary_current_sense),
    .share_digital           (share_digital),
    .share_current           (share_current),
    .share_bus_output_pin    (share_bus_output_pin),
    .share_update            (share_update)
  );

  // ****************************************
  // share loop tuning
  // ****************************************
  assign share_diff = (share_current >= share_bus_level) ? share_current - share_bus_level
                                                         : share_bus_level - share_current;
  assign in_tol_now = share_diff <= SENSE_WIDTH'(active_slt[`SLT_TOL_MSB:`SLT_TOL_LSB]);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      master_drop        <= 4'h0;
      share_in_tolerance <= 1'b1;
    end
    else
    begin
      master_drop        <= active_slt[`SLT_DROP_MSB:`SLT_DROP_LSB];
      share_in_tolerance <= in_tol_now;
    end
  end

  // ****************************************
  // volt-second balance gain and settling
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      vsb_gain_mult <= 7'h01;
    else
      vsb_gain_mult <= 7'h01 << {active_vsg[`VSG_GAIN_MSB:`VSG_GAIN_LSB], 1'b0};
  end

  // settle window shrinks with gain; code 11 uses its own figure
  assign settle_target = (active_vsg[`VSG_GAIN_MSB:`VSG_GAIN_LSB] == 2'h3)
                       ? 32'(FAST_SETTLE_CYCLES)
                       : 32'(SLOW_SETTLE_CYCLES) >> {active_vsg[`VSG_GAIN_MSB:`VSG_GAIN_LSB], 1'b0};

  always_ff @(posedge clk)
  begin
    if (rst || (cycle_start && volt_second_gain != active_vsg))
    begin
      settle_count <= 32'h0;
      vsb_settling <= 1'b1;
    end
    else if (settle_count + 32'h1 >= settle_target)
      vsb_settling <= 1'b0;
    else
      settle_count <= settle_count + 32'h1;
  end

  // ****************************************
  // temperature gain trim
  // ****************************************
  // 15/128 of the reading gives just under twelve percent at the top code
  assign trim_product = temp_raw * active_tat[`TAT_TRIM_MSB:`TAT_TRIM_LSB];
  assign trim_corr    = (SENSE_WIDTH+1)'(trim_product >> `TRIM_SHIFT);
  assign trim_sum     = active_tat[`TAT_POL_BIT] ? {1'b0, temp_raw} - trim_corr
                                                 : {1'b0, temp_raw} + trim_corr;

  always_ff @(posedge clk)
  begin
    if (rst)
      temp_trimmed <= '0;
    else if (trim_sum[SENSE_WIDTH])
      temp_trimmed <= '1; // saturate instead of wrapping to a cold reading
    else
      temp_trimmed <= trim_sum[SENSE_WIDTH-1:0];
  end

  // ****************************************
  // events and interrupt
  // ****************************************
  assign event_set[`EVT_OVERCURRENT] = oc_event;
  assign event_set[`EVT_SHARE_LOST]  = share_in_tolerance && !in_tol_now;

  always_ff @(posedge clk)
  begin
    if (rst)
      event_status <= '0;
    else if (wr && addr == `OFS_EVENT_STATUS)
      event_status <= (event_status & ~wdata[`EVT_COUNT-1:0]) | event_set;
    else
      event_status <= event_status | event_set;
  end

  assign irq = |(event_status & event_mask);

  // ****************************************
  // checks
  // ****************************************
  AST_READBACK: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == `OFS_SHARE_LOOP_TUNING) ##1 (rd && addr == `OFS_SHARE_LOOP_TUNING && !wr)
      |=> rdata == $past(wdata, 2))
    else $error("share loop tuning did not read back as written");

  AST_GAIN_MAP: assert property (@(posedge clk) disable iff (rst)
    ##1 $past(active_vsg[`VSG_GAIN_MSB:`VSG_GAIN_LSB]) == 2'h3 |-> vsb_gain_mult == 7'h40)
    else $error("top gain code does not give gain 64");

  AST_OC_STATUS: assert property (@(posedge clk) disable iff (rst)
    oc_event |=> event_status[`EVT_OVERCURRENT])
    else $error("overcurrent event not latched");

  AST_SHADOW_HOLD: assert property (@(posedge clk) disable iff (rst)
    !cycle_start |=> $stable(active_soc) && $stable(active_foc))
    else $error("setting changed inside a switching cycle");

endmodule

`default_nettype wire

/* share_bus_vsb_trim_config_tb_top.sv */
/*
  Self-checking bench for the share, volt-second and trim configuration bank.
  Assumes the design files and share_peer_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "share_trim_consts.svh"

module share_bus_vsb_trim_config_tb_top;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cycle_start = 1'b0;
  logic overcurrent_trip = 1'b0, share_digital, pin, share_update, in_tol;
  logic vsb_settling, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic [3:0] pwm_in = 4'hf, pwm_out, master_drop;
  logic [6:0] vsb_gain_mult;
  logic [11:0] prim = 12'h100, sec = 12'h10f, temp_raw = 12'h080;
  logic [11:0] level, share_current, temp_trimmed;
  logic [7:0] vals [4] = '{8'h5a, 8'h3c, 8'hc3, 8'h1f};
  int num_errors = 0, n_tests = 0, upd = 0, upd0 = 0;

  always #2 clk = ~clk;
  always @(posedge clk) if (share_update === 1'b1) upd <= upd + 1;

  share_bus_vsb_trim_config #(.SLOW_SETTLE_CYCLES(640), .FAST_SETTLE_CYCLES(10))
    u_share_bus_vsb_trim_config (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cycle_start(cycle_start),
    .overcurrent_trip(overcurrent_trip), .pwm_in(pwm_in), .pwm_out(pwm_out),
    .primary_current_sense(prim), .secondary_current_sense(sec),
    .share_digital(share_digital), .share_bus_level(level), .share_bus_output_pin(pin),
    .share_update(share_update), .share_current(share_current),
    .share_in_tolerance(in_tol), .master_drop(master_drop), .vsb_gain_mult(vsb_gain_mult),
    .vsb_settling(vsb_settling), .temp_raw(temp_raw), .temp_trimmed(temp_trimmed),
    .irq(irq));
  share_peer_model u_share_peer_model (.clk(clk), .rst(rst), .share_bus_level(level),
    .share_digital(share_digital));

  // ****************************************
  // access and checking tasks
  // ****************************************
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  // one switching cycle boundary, then time for registered outputs
  task cyc;
    @(posedge clk) cycle_start <= 1'b1;
    @(posedge clk) cycle_start <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task end_sim;
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (vals[i])
    begin
      bus_wr(8'h28 + 8'(i), vals[i]);
      bus_rd(8'h28 + 8'(i), v); chk(v, vals[i]);
    end
    bus_rd(8'h40, v); chk(v, 8'h00);
    // write then read with no gap between the strobes
    @(posedge clk) {addr, wdata, wr} <= {`OFS_SHARE_LOOP_TUNING, 8'ha5, 1'b1};
    @(posedge clk) {wr, rd} <= 2'b01;
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, 8'ha5);
    for (int c = 0; c < 4; c++)
    begin
      bus_wr(`OFS_VOLT_SECOND_GAIN, 8'(c));
      cyc; chk(vsb_gain_mult, 7'h1 << (2 * c));
    end
    repeat (20) @(posedge clk);
    chk(vsb_settling, 1'b0);
    bus_wr(`OFS_VOLT_SECOND_GAIN, 8'h00);
    cyc; repeat (30) @(posedge clk);
    chk(vsb_settling, 1'b1);
    repeat (640) @(posedge clk);
    chk(vsb_settling, 1'b0);
    bus_wr(8'h29, 8'h08);
    bus_wr(8'h2a, 8'h30);
    cyc;
    chk(share_current, 12'h100);
    chk(master_drop, 4'h3);
    // clear the stale share-lost bit so the next one is fresh
    bus_wr(`OFS_EVENT_STATUS, 8'h02);
    bus_wr(8'h29, 8'h00);
    cyc;
    chk(share_current, 12'h10f);
    chk(in_tol, 1'b0);
    bus_rd(`OFS_EVENT_STATUS, v);
    chk(v & 8'h02, 8'h02);
    bus_wr(8'h2a, 8'h3f); cyc; chk(in_tol, 1'b1);
    repeat (3) @(posedge clk) #1 chk(pin ^ share_digital, 1'b1);
    @(posedge clk) sec <= 12'h000;
    bus_wr(8'h29, 8'h10);
    cyc;
    repeat (3) @(posedge clk) #1 chk(pin, 1'b0);
    for (int b = 7; b > 5; b--)
    begin
      bus_wr(8'h29, 8'(b));
      cyc;
      upd0 = upd;
      repeat (4) cyc;
      chk(16'(upd - upd0), 16'h1 << (b - 5));
    end
    bus_wr(`OFS_THERMAL_ADC_TRIM, 8'h0f); cyc; chk(temp_trimmed, 12'h08f);
    bus_wr(`OFS_THERMAL_ADC_TRIM, 8'h1f); cyc; chk(temp_trimmed, 12'h071);
    bus_wr(`OFS_FAST_OC_CONFIG, 8'h01); bus_wr(`OFS_EVENT_MASK, 8'h01); cyc;
    @(posedge clk) overcurrent_trip <= 1'b1;
    repeat (2) @(posedge clk); #1 chk(pwm_out, 4'h0);
    cyc; bus_rd(`OFS_EVENT_STATUS, v); chk(v & 8'h01, 8'h00);
    cyc; bus_rd(`OFS_EVENT_STATUS, v); chk(v & 8'h01, 8'h01);
    chk(irq, 1'b1);
    @(posedge clk) overcurrent_trip <= 1'b0;
    cyc; chk(pwm_out, 4'hf);
    bus_wr(`OFS_EVENT_MASK, 8'h00); #1 chk(irq, 1'b0);
    bus_wr(`OFS_EVENT_MASK, 8'h01); #1 chk(irq, 1'b1);
    bus_wr(`OFS_EVENT_STATUS, 8'h03); #1 chk(irq, 1'b0);
    // timeout codes 00 and 11; the first boundary may close a tripped cycle, the second a clean one that leaves the flagged state
    for (int k = 0; k < 4; k += 3)
    begin
      bus_wr(`OFS_FAST_OC_CONFIG, 8'(k));
      cyc;
      cyc;
      bus_wr(`OFS_EVENT_STATUS, 8'h01);
      @(posedge clk) overcurrent_trip <= 1'b1;
      repeat ((1 << k) - 1) cyc;
      bus_rd(`OFS_EVENT_STATUS, v);
      chk(v & 8'h01, 8'h00);
      cyc;
      bus_rd(`OFS_EVENT_STATUS, v);
      chk(v & 8'h01, 8'h01);
      @(posedge clk) overcurrent_trip <= 1'b0;
    end
    end_sim;
  end

  // run takes about 1000 clocks; a hang is cut well beyond that
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_sim;
  end
endmodule

`default_nettype wire

/* share_peer_model.sv */
/*
  Peer supply on the share bus: drives the bus level and the digital share signal.
  Assumes one clock and a synchronous active-high reset shared with the bank.
*/
`timescale 1ns/1ns
`default_nettype none

module share_peer_model #(
  parameter logic [11:0] LEVEL = 12'h100
) (
  input  wire logic        clk,
  input  wire logic        rst,
  output var  logic [11:0] share_bus_level,
  output var  logic        share_digital
);
  // ****************************************
  // peer behaviour
  // ****************************************
  assign share_bus_level = LEVEL;
  // toggles each clock so a stale pin value never passes for a fresh one
  always_ff @(posedge clk)
  begin
    if (rst)
      share_digital <= 1'b0;
    else
      share_digital <= ~share_digital;
  end
endmodule

`default_nettype wire

/* share_select.sv */
/*
  Share-bus output selection: picks the current reading for sharing, drives
  the share output pin with either a bit stream or the digital share signal,
  and paces the share loop by the bandwidth code.
  Assumes cycle_start is a one-clock pulse per switching cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "share_trim_consts.svh"

module share_select #(
  parameter int SENSE_WIDTH = 12
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   cycle_start,
  input  wire logic                   bitstream_sel,
  input  wire logic                   source_sel,
  input  wire logic [2:0]             bandwidth,
  input  wire logic [SENSE_WIDTH-1:0] primary_current_sense,
  input  wire logic [SENSE_WIDTH-1:0] secondary_current_sense,
  input  wire logic                   share_digital,
  output var  logic [SENSE_WIDTH-1:0] share_current,
  output var  logic                   share_bus_output_pin,
  output var  logic                   share_update
);

  initial
  begin
    if (SENSE_WIDTH < 2) $error("SENSE_WIDTH must be at least 2");
  end

  logic [SENSE_WIDTH:0] sigma;
  logic [7:0]           pace;
  logic [7:0]           pace_end;

  // ****************************************
  // source and output pin
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      share_current <= '0;
    else if (share_trim_pkg::share_src_type'(source_sel) == share_trim_pkg::share_src_primary)
      share_current <= primary_current_sense;
    else
      share_current <= secondary_current_sense;
  end

  // first-order modulator; the carry is the stream bit
  always_ff @(posedge clk)
  begin
    if (rst)
      sigma <= '0;
    else
      sigma <= {1'b0, sigma[SENSE_WIDTH-1:0]} + {1'b0, share_current};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      share_bus_output_pin <= 1'b0;
    else if (bitstream_sel)
      share_bus_output_pin <= sigma[SENSE_WIDTH];
    else
      share_bus_output_pin <= share_digital;
  end

  // ****************************************
  // loop pacing
  // ****************************************
  // code 111 updates every switching cycle, each step down halves the rate
  assign pace_end = 8'h01 << (`BW_MAX_CODE - bandwidth);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pace         <= 8'h00;
      share_update <= 1'b0;
    end
    else
    begin
      share_update <= 1'b0;
      if (cycle_start)
      begin
        if (pace + 8'h01 >= pace_end)
        begin
          pace         <= 8'h00;
          share_update <= 1'b1;
        end
        else
          pace <= pace + 8'h01;
      end
    end
  end

  AST_PIN_DIGITAL: assert property (@(posedge clk) disable iff (rst)
    !bitstream_sel |=> share_bus_output_pin == $past(share_digital))
    else $error("share pin does not follow the digital share signal");

  AST_FULL_BANDWIDTH: assert property (@(posedge clk) disable iff (rst)
    (cycle_start && bandwidth == 3'h7 && $stable(bandwidth)) |=> share_update)
    else $error("top bandwidth code missed a share update");

endmodule

`default_nettype wire

/* share_trim_consts.svh */
/*
  Register offsets, field positions, reset values and timing figures of the
  share-bus, volt-second and temperature trim configuration bank.
  Assumes it is included by bare name from files that need these values.
*/
`ifndef SHARE_TRIM_CONSTS_SVH
`define SHARE_TRIM_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_VOLT_SECOND_GAIN    8'h28
`define OFS_SHARE_OUTPUT_CONFIG 8'h29
`define OFS_SHARE_LOOP_TUNING   8'h2a
`define OFS_THERMAL_ADC_TRIM    8'h2b
`define OFS_FAST_OC_CONFIG      8'h30
`define OFS_EVENT_STATUS        8'h31
`define OFS_EVENT_MASK          8'h32

// ****************************************
// field positions
// ****************************************
`define VSG_GAIN_LSB      0
`define VSG_GAIN_MSB      1
`define SOC_BW_LSB        0
`define SOC_BW_MSB        2
`define SOC_SRC_BIT       3
`define SOC_STREAM_BIT    4
`define SLT_TOL_LSB       0
`define SLT_TOL_MSB       3
`define SLT_DROP_LSB      4
`define SLT_DROP_MSB      7
`define TAT_TRIM_LSB      0
`define TAT_TRIM_MSB      3
`define TAT_POL_BIT       4
`define FOC_TIMEOUT_LSB   0
`define FOC_TIMEOUT_MSB   1
`define EVT_OVERCURRENT   0
`define EVT_SHARE_LOST    1
`define EVT_COUNT         2

// ****************************************
// reset values and fixed figures
// ****************************************
`define RESET_BYTE        8'h00
`define READ_UNMAPPED     8'h00
`define BW_MAX_CODE       3'h7
`define TRIM_SHIFT        7
`define CLK_PERIOD_NS     4
`define VSB_SLOW_MS       700
`define VSB_FAST_MS       10
`define NS_PER_MS         1000000

`endif

/* share_trim_pkg.sv */
/*
  Types shared by the configuration bank and its two helper modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package share_trim_pkg;

  typedef logic [7:0] reg_byte_type;

  typedef enum logic {
    share_src_secondary,
    share_src_primary
  } share_src_type;

  typedef enum logic [1:0] {
    guard_idle,
    guard_counting,
    guard_flagged
  } guard_state_type;

endpackage

`default_nettype wire
